// ===== rtl/tlv_pkg.sv
// Constants for the two-level vectored interrupt controller.
// Assumes a 32-bit AXI4-Lite register bus and a 25 MHz core clock.
package tlv_pkg;

  // ----------------------------------------------------------------
  // Sources, natural order, highest first
  // ----------------------------------------------------------------
  localparam int         NSRC     = 6;
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_T0   = 3'h1;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_T1   = 3'h3;
  localparam logic [2:0] SRC_SER  = 3'h4;
  localparam logic [2:0] SRC_T2   = 3'h5;

  // ----------------------------------------------------------------
  // Vectors
  // ----------------------------------------------------------------
  localparam int                    PC_W      = 16;
  localparam logic [PC_W-1:0]       VEC_RESET = 16'h0000;
  localparam logic [5:0][PC_W-1:0]  VEC_TABLE = {
    16'h002b, 16'h0023, 16'h001b, 16'h0013, 16'h000b, 16'h0003
  };

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam int         AXI_AW          = 8;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h88;
  localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'ha8;
  localparam logic [7:0] ADDR_IE_BIT_SET  = 8'hac;
  localparam logic [7:0] ADDR_IE_BIT_CLR  = 8'hb0;
  localparam logic [7:0] ADDR_IRQ_PRIO    = 8'hb8;
  localparam logic [7:0] ADDR_STATUS      = 8'hc0;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int         GLOBAL_EN_BIT = 7;
  localparam logic [7:0] IE_MASK       = 8'hbf;
  localparam logic [7:0] IE_RST        = 8'h00;
  localparam logic [7:0] IP_MASK       = 8'h3f;
  localparam logic [7:0] IP_RST        = 8'h00;

  localparam int         FLAGS_W     = 10;
  localparam int         FL_EXT0_TRG = 0;
  localparam int         FL_EXT0_REQ = 1;
  localparam int         FL_EXT1_TRG = 2;
  localparam int         FL_EXT1_REQ = 3;
  localparam int         FL_T0_OVF   = 4;
  localparam int         FL_T1_OVF   = 5;
  localparam int         FL_T2_OVF   = 6;
  localparam int         FL_T2_EDGE  = 7;
  localparam int         FL_SER_RX   = 8;
  localparam int         FL_SER_TX   = 9;
  localparam logic [9:0] FLAGS_RST   = 10'h000;

  localparam int ST_INSVC_LO = 0;
  localparam int ST_INSVC_HI = 1;
  localparam int ST_IRQ_REQ  = 2;
  localparam int ST_SRC_LSB  = 4;
  localparam int ST_DEPTH_LSB = 8;

  // ----------------------------------------------------------------
  // Bus answers and stack
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] STACK_DEPTH = 2'h2;

endpackage : tlv_pkg

// ===== rtl/tlv_pick_if.sv
// Carrier between the controller and its priority picker.
// Assumes the picker is purely combinational.
`timescale 1ns/100ps
interface tlv_pick_if;
  logic [5:0] pend;
  logic [5:0] high;
  logic       hi_valid;
  logic [2:0] hi_src;
  logic       lo_valid;
  logic [2:0] lo_src;

  modport arb (input pend, high, output hi_valid, hi_src, lo_valid,
               lo_src);
  modport ctl (output pend, high, input hi_valid, hi_src, lo_valid,
               lo_src);
endinterface : tlv_pick_if

// ===== rtl/tlv_prio_pick.sv
// Fixed natural-order picker, one result per priority level.
// Assumes pending bits are already gated by the enables.
`timescale 1ns/100ps
module tlv_prio_pick (
  // Pending set and result
  tlv_pick_if.arb pk
);

  // ----------------------------------------------------------------
  // Scan downward so the lowest index is kept last
  // ----------------------------------------------------------------
  always_comb begin
    pk.hi_valid = 1'b0;
    pk.hi_src   = 3'h0;
    pk.lo_valid = 1'b0;
    pk.lo_src   = 3'h0;
    for (int i = tlv_pkg::NSRC - 1; i >= 0; i--) begin
      if (pk.pend[i] && pk.high[i]) begin
        pk.hi_valid = 1'b1;
        pk.hi_src   = 3'(i);
      end
      if (pk.pend[i] && !pk.high[i]) begin
        pk.lo_valid = 1'b1;
        pk.lo_src   = 3'(i);
      end
    end
  end

endmodule : tlv_prio_pick

// ===== rtl/tlv_ret_stack.sv
// Return-address stack, one slot per priority level.
// A push and a pop in the same cycle: the push wins unless the stack is full.
`timescale 1ns/100ps
module tlv_ret_stack (
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Stack access
  input  wire logic        push,
  input  wire logic [15:0] push_pc,
  input  wire logic        pop,
  output logic      [15:0] top_pc,
  output logic      [1:0]  depth
);

  logic [15:0] slot [2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      depth <= 2'h0;
    end else if (ce) begin
      if (push && depth != tlv_pkg::STACK_DEPTH) begin
        depth <= depth + 2'h1;
      end else if (pop && depth != 2'h0) begin
        depth <= depth - 2'h1;
      end
    end
  end

  // Storage has no reset; an empty stack reads as zero
  always_ff @(posedge aclk) begin
    if (ce && push && depth != tlv_pkg::STACK_DEPTH) begin
      slot[depth[0]] <= push_pc;
    end
  end

  assign top_pc = (depth == 2'h0) ? 16'h0000 : slot[~depth[0]];

endmodule : tlv_ret_stack

// ===== rtl/tlv_irq_ctrl.sv
// Two-level vectored interrupt controller with AXI4-Lite registers.
// Assumes pins and event pulses are synchronous to aclk and that the
// core takes an offer with irq_take only while irq_req is high.
//
// Contract
// - Global enable low blocks every acknowledge
// - Each source gated by its enable bit
// - Fixed vectors per source, reset at zero
// - Edge mode: falling pin edge sets flag
// - Level mode: low pin raises the request
// - External request flags readable by software
// - Edge external flag cleared on service
// - Timer rollover requests, not timer0 mode three
// - Timer 0/1 overflow flags cleared on service
// - Timer2 request from overflow or pin edge
// - Timer2 flags never cleared on service
// - Software flag writes act like hardware
// - Serial rx or tx shares one request
// - Accept: push return, mark busy, vector
// - Return pops address and clears busy level
// - Enable register resets to all zero
// - Enable bits changeable singly in one write
// - Fixed natural order within one level
// - High priority bit beats all low sources
`timescale 1ns/100ps
module tlv_irq_ctrl (
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  // Pins
  input  wire logic        ext_line_0,
  input  wire logic        ext_line_1,
  input  wire logic        timer2_capture_pin,
  // Peripheral events
  input  wire logic        timer0_rollover,
  input  wire logic        timer0_mode3,
  input  wire logic        timer1_rollover,
  input  wire logic        timer2_rollover,
  input  wire logic        serial_rx_done,
  input  wire logic        serial_tx_done,
  // Core sequencer
  output logic             irq_req,
  output logic      [15:0] irq_vector,
  input  wire logic        irq_take,
  input  wire logic [15:0] irq_next_pc,
  input  wire logic        return_from_irq_instr,
  output logic             resume_valid,
  output logic      [15:0] resume_pc
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  interrupt_enable;
  logic [7:0]  interrupt_priority;
  logic [9:0]  event_flags;
  logic [9:0]  next_flags;
  logic        in_service_hi;
  logic        in_service_lo;
  logic [2:0]  pin_prev;
  logic [2:0]  pin_now;
  logic [2:0]  fall;
  logic [5:0]  raw_req;
  logic [2:0]  offer_src;
  logic        offer_hi;
  logic        cand_valid;
  logic [2:0]  cand_src;
  logic        cand_hi;
  logic        accept;
  logic        ret;
  logic [15:0] stack_top;
  logic [1:0]  stack_depth;
  logic        aw_have;
  logic        w_have;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic        wr_hit;
  logic [31:0] wmask;
  logic [31:0] rd_val;
  logic        rd_hit;

  tlv_pick_if pick ();

  // ----------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------
  assign pin_now = {timer2_capture_pin, ext_line_1, ext_line_0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev <= 3'h7;
    end else if (ce) begin
      pin_prev <= pin_now;
    end
  end

  // A one-cycle sample per clock; slower edge sources are assumed
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_fall
      assign fall[g] = pin_prev[g] & ~pin_now[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Request gating and priority
  // ----------------------------------------------------------------
  assign raw_req = {
    event_flags[tlv_pkg::FL_T2_OVF] | event_flags[tlv_pkg::FL_T2_EDGE],
    event_flags[tlv_pkg::FL_SER_RX] | event_flags[tlv_pkg::FL_SER_TX],
    event_flags[tlv_pkg::FL_T1_OVF],
    event_flags[tlv_pkg::FL_EXT1_REQ],
    event_flags[tlv_pkg::FL_T0_OVF],
    event_flags[tlv_pkg::FL_EXT0_REQ]
  };

  assign pick.pend = raw_req & interrupt_enable[5:0]
    & {6{interrupt_enable[tlv_pkg::GLOBAL_EN_BIT]}};
  assign pick.high = interrupt_priority[5:0];

  tlv_prio_pick u_pick (
    .pk (pick)
  );

  // High may interrupt low; nothing interrupts an equal level
  always_comb begin
    cand_valid = 1'b0;
    cand_src   = 3'h0;
    cand_hi    = 1'b0;
    if (pick.hi_valid && !in_service_hi) begin
      cand_valid = 1'b1;
      cand_src   = pick.hi_src;
      cand_hi    = 1'b1;
    end else if (pick.lo_valid && !in_service_hi && !in_service_lo) begin
      cand_valid = 1'b1;
      cand_src   = pick.lo_src;
    end
  end

  assign accept = irq_take & irq_req;
  assign ret    = return_from_irq_instr & (in_service_hi | in_service_lo);

  // ----------------------------------------------------------------
  // Offer to the core
  // ----------------------------------------------------------------
  // Dropped for one cycle after a take so a stale offer is not retaken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req    <= 1'b0;
      irq_vector <= tlv_pkg::VEC_RESET;
      offer_src  <= 3'h0;
      offer_hi   <= 1'b0;
    end else if (ce) begin
      irq_req <= cand_valid & ~irq_take;
      if (!irq_take && cand_valid) begin
        irq_vector <= tlv_pkg::VEC_TABLE[cand_src];
        offer_src  <= cand_src;
        offer_hi   <= cand_hi;
      end
    end
  end

  // ----------------------------------------------------------------
  // In-service levels and return
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_service_hi <= 1'b0;
      in_service_lo <= 1'b0;
    end else if (ce) begin
      if (accept) begin
        if (offer_hi) begin
          in_service_hi <= 1'b1;
        end else begin
          in_service_lo <= 1'b1;
        end
      end else if (ret) begin
        if (in_service_hi) begin
          in_service_hi <= 1'b0;
        end else begin
          in_service_lo <= 1'b0;
        end
      end
    end
  end

  tlv_ret_stack u_stack (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .push    (accept),
    .push_pc (irq_next_pc),
    .pop     (ret),
    .top_pc  (stack_top),
    .depth   (stack_depth)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resume_valid <= 1'b0;
      resume_pc    <= 16'h0000;
    end else if (ce) begin
      resume_valid <= ret & ~accept;
      if (ret && !accept) begin
        resume_pc <= stack_top;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  // Order: service clear, then software write, then hardware set,
  // so a set arriving with a clear is never lost
  always_comb begin
    next_flags = event_flags;
    if (accept) begin
      if (offer_src == tlv_pkg::SRC_EXT0
          && event_flags[tlv_pkg::FL_EXT0_TRG]) begin
        next_flags[tlv_pkg::FL_EXT0_REQ] = 1'b0;
      end
      if (offer_src == tlv_pkg::SRC_EXT1
          && event_flags[tlv_pkg::FL_EXT1_TRG]) begin
        next_flags[tlv_pkg::FL_EXT1_REQ] = 1'b0;
      end
      if (offer_src == tlv_pkg::SRC_T0) begin
        next_flags[tlv_pkg::FL_T0_OVF] = 1'b0;
      end
      if (offer_src == tlv_pkg::SRC_T1) begin
        next_flags[tlv_pkg::FL_T1_OVF] = 1'b0;
      end
      // Timer 2 and serial flags stay set for software
    end
    if (wr_go && aw_addr == tlv_pkg::ADDR_EVENT_FLAGS) begin
      next_flags = (next_flags & ~wmask[9:0])
        | (w_data[9:0] & wmask[9:0]);
    end
    if (event_flags[tlv_pkg::FL_EXT0_TRG] ? fall[0] : !pin_now[0]) begin
      next_flags[tlv_pkg::FL_EXT0_REQ] = 1'b1;
    end
    if (event_flags[tlv_pkg::FL_EXT1_TRG] ? fall[1] : !pin_now[1]) begin
      next_flags[tlv_pkg::FL_EXT1_REQ] = 1'b1;
    end
    if (timer0_rollover && !timer0_mode3) begin
      next_flags[tlv_pkg::FL_T0_OVF] = 1'b1;
    end
    if (timer1_rollover) begin
      next_flags[tlv_pkg::FL_T1_OVF] = 1'b1;
    end
    if (timer2_rollover) begin
      next_flags[tlv_pkg::FL_T2_OVF] = 1'b1;
    end
    if (fall[2]) begin
      next_flags[tlv_pkg::FL_T2_EDGE] = 1'b1;
    end
    if (serial_rx_done) begin
      next_flags[tlv_pkg::FL_SER_RX] = 1'b1;
    end
    if (serial_tx_done) begin
      next_flags[tlv_pkg::FL_SER_TX] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_flags <= tlv_pkg::FLAGS_RST;
    end else if (ce) begin
      event_flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // Enable and priority registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_enable <= tlv_pkg::IE_RST;
    end else if (ce && wr_go && w_strb[0]) begin
      unique case (aw_addr)
        tlv_pkg::ADDR_IRQ_ENABLE:
          interrupt_enable <= w_data[7:0] & tlv_pkg::IE_MASK;
        tlv_pkg::ADDR_IE_BIT_SET:
          interrupt_enable <= (interrupt_enable | w_data[7:0])
            & tlv_pkg::IE_MASK;
        tlv_pkg::ADDR_IE_BIT_CLR:
          interrupt_enable <= interrupt_enable & ~w_data[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_priority <= tlv_pkg::IP_RST;
    end else if (ce && wr_go && w_strb[0]
                 && aw_addr == tlv_pkg::ADDR_IRQ_PRIO) begin
      interrupt_priority <= w_data[7:0] & tlv_pkg::IP_MASK;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign wr_go = aw_have & w_have & ~s_axi_bvalid;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                  {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wr_hit = aw_addr == tlv_pkg::ADDR_EVENT_FLAGS
    || aw_addr == tlv_pkg::ADDR_IRQ_ENABLE
    || aw_addr == tlv_pkg::ADDR_IE_BIT_SET
    || aw_addr == tlv_pkg::ADDR_IE_BIT_CLR
    || aw_addr == tlv_pkg::ADDR_IRQ_PRIO
    || aw_addr == tlv_pkg::ADDR_STATUS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have       <= 1'b0;
      aw_addr       <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_go) begin
        aw_have <= 1'b0;
      end else if (!aw_have && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_go) begin
        w_have <= 1'b0;
      end else if (!w_have && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= tlv_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? tlv_pkg::RESP_OKAY
                               : tlv_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      tlv_pkg::ADDR_EVENT_FLAGS: rd_val[9:0] = event_flags;
      tlv_pkg::ADDR_IRQ_ENABLE:  rd_val[7:0] = interrupt_enable;
      tlv_pkg::ADDR_IRQ_PRIO:    rd_val[7:0] = interrupt_priority;
      tlv_pkg::ADDR_IE_BIT_SET,
      tlv_pkg::ADDR_IE_BIT_CLR:  rd_val = 32'h0000_0000;
      tlv_pkg::ADDR_STATUS: begin
        rd_val[tlv_pkg::ST_INSVC_LO] = in_service_lo;
        rd_val[tlv_pkg::ST_INSVC_HI] = in_service_hi;
        rd_val[tlv_pkg::ST_IRQ_REQ]  = irq_req;
        rd_val[tlv_pkg::ST_SRC_LSB +: 3]   = offer_src;
        rd_val[tlv_pkg::ST_DEPTH_LSB +: 2] = stack_depth;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tlv_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_hit ? tlv_pkg::RESP_OKAY
                                : tlv_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : tlv_irq_ctrl

// ===== verification/tlv_core_model.sv
// Behavioural core sequencer that takes interrupt offers.
// Assumes aclk is the controller clock; lag sets how slow it answers.
`timescale 1ns/100ps
module tlv_core_model (
  // Clock and control
  input  wire logic        aclk,
  input  wire logic        go,
  input  wire logic [2:0]  lag,
  // Offer and take
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  output logic             irq_take,
  output logic      [15:0] irq_next_pc
);
  logic [2:0] wt = 3'h0;
  initial irq_take = 1'b0;
  initial irq_next_pc = 16'h1000;
  // Take only a standing offer, once, after lag idle cycles
  always @(posedge aclk) begin
    irq_take <= 1'b0;
    if (go && irq_req && !irq_take) begin
      if (wt >= lag) begin
        irq_take    <= 1'b1;
        irq_next_pc <= irq_next_pc + 16'h0100;
        wt          <= 3'h0;
      end else begin
        wt <= wt + 3'h1;
      end
    end else begin
      wt <= 3'h0;
    end
  end
endmodule : tlv_core_model

// ===== verification/tlv_irq_ctrl_assertions.sv
// Port checker for the interrupt controller.
// Assumes one clock domain and synchronous active-low reset.
`timescale 1ns/100ps
module tlv_irq_ctrl_assertions (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  // Bus answers
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Core side
  input wire logic        irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic        irq_take,
  input wire logic        return_from_irq_instr,
  input wire logic        resume_valid
);
  logic [1:0] lvl;
  // Nesting depth seen from the handshake; take beats return
  always_ff @(posedge aclk) begin
    if (!aresetn)
      lvl <= 2'h0;
    else if (ce && irq_take && irq_req)
      lvl <= lvl + 2'h1;
    else if (ce && return_from_irq_instr && lvl != 2'h0)
      lvl <= lvl - 2'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_take;
    ce && irq_take && irq_req;
  endsequence
  sequence s_ret;
    ce && return_from_irq_instr && !(irq_take && irq_req) && lvl != 2'h0;
  endsequence
  property p_take_drop;
    s_take |=> !irq_req;
  endproperty
  a_take_drop: assert property (p_take_drop) else $error("req kept");
  property p_resume;
    s_ret |=> resume_valid;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  property p_no_resume;
    ce && !return_from_irq_instr |=> !resume_valid;
  endproperty
  a_no_resume: assert property (p_no_resume) else $error("stray pop");
  property p_vector;
    irq_req |-> irq_vector inside {16'h0003, 16'h000b, 16'h0013,
                                   16'h001b, 16'h0023, 16'h002b};
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector");
  property p_nest;
    s_take |-> lvl != 2'h2;
  endproperty
  a_nest: assert property (p_nest) else $error("third level");
  property p_full;
    lvl == 2'h2 |-> !irq_req;
  endproperty
  a_full: assert property (p_full) else $error("offer when full");
  property p_bdone;
    ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bdone: assert property (p_bdone) else $error("bvalid kept");
  property p_rdone;
    ce && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rdone: assert property (p_rdone) else $error("rvalid kept");
endmodule : tlv_irq_ctrl_assertions
bind tlv_irq_ctrl tlv_irq_ctrl_assertions u_chk (.*);

// ===== verification/tb.sv
// Self-checking bench for the interrupt controller.
// Assumes a core model answering offers and an AXI4-Lite master here.
`timescale 1ns/100ps
module tb;
  logic aclk, aresetn, ce, go, irq_req, irq_take, resume_valid;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, return_from_irq_instr;
  logic ext_line_0, ext_line_1, timer2_capture_pin, timer0_mode3;
  logic timer0_rollover, timer1_rollover, timer2_rollover;
  logic serial_rx_done, serial_tx_done;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] irq_vector, irq_next_pc, resume_pc;
  logic [15:0] pcs[$];
  logic [2:0]  lag;
  int n_mismatch, n_tests, k;
  tlv_irq_ctrl DUT (.*);
  tlv_core_model u_core (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task end_sim;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task lim;
    if (k >= 60) begin
      n_mismatch++;
      end_sim();
    end
  endtask : lim
  task wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= v;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 60);
    r = s_axi_bresp;
    lim();
  endtask : wr
  task rd(input logic [7:0] a);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 60);
    d = s_axi_rdata;
    r = s_axi_rresp;
    lim();
  endtask : rd
  task take(input logic [15:0] v);
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (!(irq_take && irq_req) && k < 60);
    chk(irq_vector, v);
    pcs.push_back(irq_next_pc);
    lim();
  endtask : take
  task ret;
    return_from_irq_instr <= 1'b1;
    @(posedge aclk);
    return_from_irq_instr <= 1'b0;
    @(posedge aclk);
    chk(resume_valid, 1);
    chk(resume_pc, pcs.pop_back());
  endtask : ret
  task t_regs;
    rd(8'ha8);
    chk(d, 0);
    wr(8'ha8, 32'hff);
    wr(8'hb0, 32'h81);
    chk(r, 0);
    rd(8'ha8);
    chk(d, 32'h3e);
    rd(8'h04);
    chk(r, 2);
    wr(8'h04, 32'h0);
    chk(r, 2);
    $display("t_regs done");
  endtask : t_regs
  task t_ev;
    wr(8'ha8, 32'h3d);
    go <= 1'b1;
    {timer0_rollover, timer1_rollover, timer2_rollover} <= 3'h7;
    {serial_rx_done, serial_tx_done, timer2_capture_pin} <= 3'h6;
    @(posedge aclk);
    {timer0_rollover, timer1_rollover, timer2_rollover} <= 3'h0;
    {serial_rx_done, serial_tx_done, timer2_capture_pin} <= 3'h1;
    tick(3);
    chk(irq_req, 0);
    rd(8'h88);
    chk(d, 32'h3f0);
    wr(8'hac, 32'h80);
    take(16'h001b);
    rd(8'h88);
    chk(d, 32'h3d0);
    go <= 1'b0;
    ret();
    wr(8'h88, 32'h0);
    wr(8'ha8, 32'h82);
    timer0_mode3 <= 1'b1;
    timer0_rollover <= 1'b1;
    @(posedge aclk);
    timer0_rollover <= 1'b0;
    rd(8'h88);
    chk(d, 0);
    timer0_mode3 <= 1'b0;
    timer0_rollover <= 1'b1;
    @(posedge aclk);
    timer0_rollover <= 1'b0;
    go <= 1'b1;
    take(16'h000b);
    rd(8'h88);
    chk(d, 0);
    ret();
    $display("t_ev done");
  endtask : t_ev
  task t_prio;
    go  <= 1'b0;
    lag <= 3'h3;
    wr(8'ha8, 32'hbf);
    wr(8'h88, 32'h3f0);
    tick(3);
    chk(irq_vector, 16'h000b);
    wr(8'hb8, 32'h20);
    tick(3);
    chk(irq_vector, 16'h002b);
    go <= 1'b1;
    take(16'h002b);
    tick(3);
    chk(irq_req, 0);
    rd(8'h88);
    chk(d, 32'h3f0);
    wr(8'h88, 32'h330);
    ret();
    take(16'h000b);
    wr(8'hb8, 32'h08);
    take(16'h001b);
    ret();
    ret();
    take(16'h0023);
    rd(8'h88);
    chk(d, 32'h300);
    go <= 1'b0;
    ret();
    wr(8'h88, 32'h0);
    wr(8'hb8, 32'h0);
    $display("t_prio done");
  endtask : t_prio
  task t_ext;
    wr(8'h88, 32'h1);
    ext_line_0 <= 1'b0;
    tick(12);
    ext_line_0 <= 1'b1;
    rd(8'h88);
    chk(d, 32'h3);
    go <= 1'b1;
    take(16'h0003);
    rd(8'h88);
    chk(d, 32'h1);
    ret();
    go <= 1'b0;
    ext_line_1 <= 1'b0;
    tick(2);
    ext_line_1 <= 1'b1;
    go <= 1'b1;
    take(16'h0013);
    rd(8'h88);
    chk(d, 32'h9);
    wr(8'h88, 32'h1);
    ret();
    $display("t_ext done");
  endtask : t_ext
  initial begin
    {ce, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7f;
    {aresetn, go, lag, return_from_irq_instr, timer0_mode3} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {ext_line_0, ext_line_1, timer2_capture_pin} = 3'h7;
    {timer0_rollover, timer1_rollover, timer2_rollover} = 3'h0;
    {serial_rx_done, serial_tx_done} = 2'h0;
    tick(5);
    aresetn <= 1'b1;
    tick(1);
    t_regs();
    t_ev();
    t_prio();
    t_ext();
    end_sim();
  end
endmodule : tb
